/* sis_alu.sv */
// Purpose : Shared constants and the datapath for the skip and set instruction group
// Assumes : Operand byte is the data memory byte already read for the current instruction
// Notes   : The datapath is purely combinational; the executor registers every result

`timescale 1ns/1ps

package sis_pkg;

	// Instruction kinds handed over by the decode stage
	typedef enum logic [2:0] {
		SIS_OP_NONE      = 3'h0,
		SIS_OP_DEC_ACC   = 3'h1,
		SIS_OP_DEC_MEM   = 3'h2,
		SIS_OP_INC_MEM   = 3'h3,
		SIS_OP_INC_ACC   = 3'h4,
		SIS_OP_SET_ALL   = 3'h5,
		SIS_OP_SET_BIT   = 3'h6,
		SIS_OP_SKIP_BIT  = 3'h7
	} sis_op_e;

	// Executor states, one-hot
	typedef enum logic [1:0] {
		SIS_ST_EXEC  = 2'h1,
		SIS_ST_DUMMY = 2'h2
	} sis_state_e;

	localparam int          SIS_DATA_W   = 8;
	localparam int          SIS_ADDR_W   = 8;
	localparam int          SIS_BIT_W    = 3;
	localparam logic [7:0]  SIS_ACC_RST  = 8'h00;
	localparam logic [7:0]  SIS_ADDR_RST = 8'h00;
	localparam logic [7:0]  SIS_WDAT_RST = 8'h00;
	localparam logic [7:0]  SIS_ALL_ONES = 8'hff;
	localparam logic [7:0]  SIS_ONE      = 8'h01;
	localparam logic [7:0]  SIS_ZERO     = 8'h00;

endpackage

module sis_alu (
	input  wire sis_pkg::sis_op_e op,
	input  wire logic [7:0]       operand,
	input  wire logic [2:0]       bit_sel,
	output logic      [7:0]       result,
	output logic                  wr_mem,
	output logic                  wr_acc,
	output logic                  skip
);

	logic [7:0] dec_val;
	logic [7:0] inc_val;
	logic [7:0] bit_mask;

	// Shared adders and the bit mask
	assign dec_val  = 8'(operand - sis_pkg::SIS_ONE);
	assign inc_val  = 8'(operand + sis_pkg::SIS_ONE);
	assign bit_mask = 8'(sis_pkg::SIS_ONE << bit_sel);

	// Result, destination and skip decision per instruction kind
	always_comb begin
		result = operand;
		wr_mem = 1'b0;
		wr_acc = 1'b0;
		skip   = 1'b0;
		case (op)
			sis_pkg::SIS_OP_DEC_ACC: begin
				result = dec_val;
				wr_acc = 1'b1;
				skip   = (dec_val == sis_pkg::SIS_ZERO);
			end
			sis_pkg::SIS_OP_DEC_MEM: begin
				result = dec_val;
				wr_mem = 1'b1;
				skip   = (dec_val == sis_pkg::SIS_ZERO);
			end
			sis_pkg::SIS_OP_INC_MEM: begin
				result = inc_val;
				wr_mem = 1'b1;
				skip   = (inc_val == sis_pkg::SIS_ZERO);
			end
			sis_pkg::SIS_OP_INC_ACC: begin
				result = inc_val;
				wr_acc = 1'b1;
				skip   = (inc_val == sis_pkg::SIS_ZERO);
			end
			sis_pkg::SIS_OP_SET_ALL: begin
				result = sis_pkg::SIS_ALL_ONES;
				wr_mem = 1'b1;
			end
			sis_pkg::SIS_OP_SET_BIT: begin
				result = operand | bit_mask;
				wr_mem = 1'b1;
			end
			sis_pkg::SIS_OP_SKIP_BIT: begin
				skip = ((operand & bit_mask) != sis_pkg::SIS_ZERO);
			end
			default: begin
				result = operand;
			end
		endcase
	end

endmodule

/* sis_exec.sv */
// Purpose : Executes the skip and set instruction group between decode and data memory
// Assumes : Decode presents one instruction per cycle with its operand byte already read
// Notes   : A skip replaces the next fetched instruction by a dummy cycle
//           Every output is registered, so results show one cycle after an instruction is taken
//           The checks sit beside the logic that they guard
//
// How it works
// - Decrement to accumulator, memory byte untouched
// - Decrement to accumulator skips when result zero
// - Skip inserts one dummy cycle, two total
// - Nonzero test result runs next instruction normally
// - Set all writes all ones to memory
// - Set bit forces one bit, others kept
// - Increment memory, write back, skip on zero
// - Increment to accumulator, skip on zero
// - Bit test skips when selected bit set
// - No status flag changes for this group
// - Decrement memory, write back, skip on zero

`timescale 1ns/1ps

module sis_exec (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             op_valid,
	input  wire sis_pkg::sis_op_e op,
	input  wire logic [7:0]       op_addr,
	input  wire logic [2:0]       op_bit,
	input  wire logic [7:0]       mem_rdata,
	output logic                  mem_we,
	output logic      [7:0]       mem_waddr,
	output logic      [7:0]       mem_wdata,
	output logic      [7:0]       accumulator,
	output logic                  squash,
	output logic                  flags_we,
	output logic                  op_done
);

	sis_pkg::sis_state_e state_reg;
	sis_pkg::sis_state_e state_next;

	logic       mem_we_reg;
	logic [7:0] mem_waddr_reg;
	logic [7:0] mem_wdata_reg;
	logic [7:0] accumulator_reg;
	logic       squash_reg;
	logic       flags_we_reg;
	logic       op_done_reg;

	logic [7:0] alu_result;
	logic       alu_wr_mem;
	logic       alu_wr_acc;
	logic       alu_skip;
	logic       go;
	logic       acc_form;
	logic       mem_form;

	// An instruction runs only outside a dummy slot
	assign go = op_valid && (state_reg == sis_pkg::SIS_ST_EXEC);

	// Instruction classes used by the checks below
	assign acc_form = (op == sis_pkg::SIS_OP_DEC_ACC) || (op == sis_pkg::SIS_OP_INC_ACC);
	assign mem_form = (op == sis_pkg::SIS_OP_DEC_MEM) || (op == sis_pkg::SIS_OP_INC_MEM)
		|| (op == sis_pkg::SIS_OP_SET_ALL) || (op == sis_pkg::SIS_OP_SET_BIT);

	// Datapath for the whole group
	sis_alu u_alu (
		.op      (op),
		.operand (mem_rdata),
		.bit_sel (op_bit),
		.result  (alu_result),
		.wr_mem  (alu_wr_mem),
		.wr_acc  (alu_wr_acc),
		.skip    (alu_skip)
	);

	// Next state: a met skip turns the following slot into a dummy
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sis_pkg::SIS_ST_EXEC: begin
				if (go && alu_skip) begin
					state_next = sis_pkg::SIS_ST_DUMMY;
				end else begin
					state_next = sis_pkg::SIS_ST_EXEC;
				end
			end
			sis_pkg::SIS_ST_DUMMY: begin
				state_next = sis_pkg::SIS_ST_EXEC;         // Dummy lasts one cycle
			end
			default: begin
				state_next = sis_pkg::SIS_ST_EXEC;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= sis_pkg::SIS_ST_EXEC;
		end else begin
			state_reg <= state_next;
		end
	end

	// Squash flag, high during the dummy slot that replaces the next fetch
	always_ff @(posedge clk) begin
		if (rst) begin
			squash_reg <= 1'b0;
		end else begin
			squash_reg <= (state_next == sis_pkg::SIS_ST_DUMMY);
		end
	end

	// Data memory write port; the squashed slot never writes
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_we_reg    <= 1'b0;
			mem_waddr_reg <= sis_pkg::SIS_ADDR_RST;
			mem_wdata_reg <= sis_pkg::SIS_WDAT_RST;
		end else begin
			mem_we_reg <= go && alu_wr_mem;
			if (go && alu_wr_mem) begin
				mem_waddr_reg <= op_addr;
				mem_wdata_reg <= alu_result;
			end
		end
	end

	// Accumulator, loaded only by the to-accumulator forms
	always_ff @(posedge clk) begin
		if (rst) begin
			accumulator_reg <= sis_pkg::SIS_ACC_RST;
		end else if (go && alu_wr_acc) begin
			accumulator_reg <= alu_result;
		end
	end

	// Status flags are never written by this group
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_we_reg <= 1'b0;
		end else begin
			flags_we_reg <= 1'b0;
		end
	end

	// Completion pulse for each instruction actually executed
	always_ff @(posedge clk) begin
		if (rst) begin
			op_done_reg <= 1'b0;
		end else begin
			op_done_reg <= go && (op != sis_pkg::SIS_OP_NONE);
		end
	end

	// Outputs straight from flip-flops
	assign mem_we      = mem_we_reg;
	assign mem_waddr   = mem_waddr_reg;
	assign mem_wdata   = mem_wdata_reg;
	assign accumulator = accumulator_reg;
	assign squash      = squash_reg;
	assign flags_we    = flags_we_reg;
	assign op_done     = op_done_reg;

	// Decrement to accumulator loads operand minus one, no memory write
	a_dec_acc_value: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_DEC_ACC)
		|=> (accumulator == 8'($past(mem_rdata) - 8'h01)) && !mem_we)
		else $error("decrement to accumulator result wrong");

	// Decrement to accumulator skips exactly when the operand was one
	a_dec_acc_skip: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_DEC_ACC)
		|=> (squash == ($past(mem_rdata) == 8'h01)))
		else $error("decrement to accumulator skip wrong");

	// A dummy slot lasts one cycle and is followed by a live slot
	a_dummy_one_slot: assert property (@(posedge clk) disable iff (rst)
		squash |=> !squash)
		else $error("dummy slot longer than one cycle");

	// No dummy when the skip test fails
	a_no_skip_live: assert property (@(posedge clk) disable iff (rst)
		(go && !alu_skip) |=> !squash)
		else $error("dummy inserted without a skip");

	// Set all writes all ones to the addressed byte
	a_set_all_ones: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_SET_ALL)
		|=> mem_we && (mem_wdata == 8'hff) && (mem_waddr == $past(op_addr)) && !squash)
		else $error("set all wrote wrong value");

	// Set bit forces only the chosen bit
	a_set_one_bit: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_SET_BIT)
		|=> mem_we && (mem_wdata == ($past(mem_rdata) | 8'(8'h01 << $past(op_bit)))))
		else $error("set bit wrote wrong value");

	// Increment to memory writes back and skips on wrap to zero
	a_inc_mem_skip: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_INC_MEM)
		|=> mem_we && (mem_wdata == 8'($past(mem_rdata) + 8'h01))
		&& (squash == ($past(mem_rdata) == 8'hff)))
		else $error("increment to memory wrong");

	// Increment to accumulator leaves memory alone and skips on zero
	a_inc_acc_skip: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_INC_ACC)
		|=> !mem_we && (accumulator == 8'($past(mem_rdata) + 8'h01))
		&& (squash == (accumulator == 8'h00)))
		else $error("increment to accumulator wrong");

	// Bit test skips exactly when the chosen bit is set
	a_bit_test_skip: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_SKIP_BIT)
		|=> !mem_we && (squash == $past(mem_rdata[op_bit])))
		else $error("bit test skip wrong");

	// Flags are never written
	a_flags_kept: assert property (@(posedge clk) disable iff (rst)
		!flags_we)
		else $error("status flags written");

	// Decrement to memory writes back and skips on zero
	a_dec_mem_skip: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_DEC_MEM)
		|=> mem_we && (mem_wdata == 8'($past(mem_rdata) - 8'h01))
		&& (squash == ($past(mem_rdata) == 8'h01)))
		else $error("decrement to memory wrong");

	// The squashed instruction changes neither memory nor accumulator
	a_squash_is_nop: assert property (@(posedge clk) disable iff (rst)
		squash |=> !mem_we && $stable(accumulator) && !op_done)
		else $error("squashed instruction had an effect");

	// Every executed instruction other than none gives a completion pulse
	a_done_follows_op: assert property (@(posedge clk) disable iff (rst)
		(go && op != sis_pkg::SIS_OP_NONE) |=> op_done)
		else $error("completion pulse missing");

	// No completion pulse without an executed instruction
	a_done_needs_op: assert property (@(posedge clk) disable iff (rst)
		!(go && op != sis_pkg::SIS_OP_NONE) |=> !op_done)
		else $error("completion pulse without an instruction");

	// Only the two accumulator forms may change the accumulator
	a_acc_only_acc: assert property (@(posedge clk) disable iff (rst)
		!(go && acc_form) |=> $stable(accumulator))
		else $error("accumulator changed by another instruction");

	// Only the memory forms may write memory
	a_mem_only_mem: assert property (@(posedge clk) disable iff (rst)
		!(go && mem_form) |=> !mem_we)
		else $error("memory written by a non-writing instruction");

	// Memory forms write back to the operand address
	a_mem_form_addr: assert property (@(posedge clk) disable iff (rst)
		(go && mem_form) |=> mem_we && (mem_waddr == $past(op_addr)))
		else $error("memory write address wrong");

	// The set forms never skip
	a_set_never_skips: assert property (@(posedge clk) disable iff (rst)
		(go && (op == sis_pkg::SIS_OP_SET_ALL || op == sis_pkg::SIS_OP_SET_BIT))
		|=> !squash)
		else $error("set instruction skipped");

	// The write port holds address and data between writes
	a_wport_held: assert property (@(posedge clk) disable iff (rst)
		(!mem_we && !$past(rst))
		|-> ($stable(mem_waddr) && $stable(mem_wdata)))
		else $error("write port moved without a write");

	// State stays one-hot and the squash output mirrors the dummy state
	a_state_onehot: assert property (@(posedge clk) disable iff (rst)
		$onehot(state_reg) && (squash == (state_reg == sis_pkg::SIS_ST_DUMMY)))
		else $error("state and squash disagree");

	// A dummy slot only ever follows a met skip
	a_skip_needs_go: assert property (@(posedge clk) disable iff (rst)
		squash |-> $past(go && alu_skip))
		else $error("dummy slot without a skip");

	// An empty instruction has no effect at all
	a_none_no_effect: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_NONE)
		|=> !mem_we && !squash && !op_done)
		else $error("empty instruction had an effect");

	// Decrement to accumulator leaves the memory write port alone
	a_dec_acc_mem_kept: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_DEC_ACC)
		|=> $stable(mem_waddr) && $stable(mem_wdata))
		else $error("decrement to accumulator touched memory");

	// Increment to accumulator leaves the memory write port alone
	a_inc_acc_mem_kept: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_INC_ACC)
		|=> $stable(mem_waddr) && $stable(mem_wdata))
		else $error("increment to accumulator touched memory");

	// Bit test leaves the accumulator and completes
	a_bit_test_quiet: assert property (@(posedge clk) disable iff (rst)
		(go && op == sis_pkg::SIS_OP_SKIP_BIT) |=> $stable(accumulator) && op_done)
		else $error("bit test changed the accumulator");

endmodule

/* tb_sis_exec.sv */
// Purpose : Self-checking bench for the skip and set instruction executor
// Assumes : Outputs update on the edge that takes an instruction and are sampled just after it
// Notes   : Each scenario drives decode-side ports directly and judges the results

`timescale 1ns/1ps

module tb_sis_exec;

	logic             clk;
	logic             rst;
	logic             op_valid;
	sis_pkg::sis_op_e op;
	logic [7:0]       op_addr;
	logic [2:0]       op_bit;
	logic [7:0]       mem_rdata;
	logic             mem_we;
	logic [7:0]       mem_waddr;
	logic [7:0]       mem_wdata;
	logic [7:0]       accumulator;
	logic             squash;
	logic             flags_we;
	logic             op_done;
	int               failures;
	int               n_checks;

	sis_exec DUT (
		.clk         (clk),
		.rst         (rst),
		.op_valid    (op_valid),
		.op          (op),
		.op_addr     (op_addr),
		.op_bit      (op_bit),
		.mem_rdata   (mem_rdata),
		.mem_we      (mem_we),
		.mem_waddr   (mem_waddr),
		.mem_wdata   (mem_wdata),
		.accumulator (accumulator),
		.squash      (squash),
		.flags_we    (flags_we),
		.op_done     (op_done)
	);

	// Free-running 10 MHz clock
	always #50 clk = ~clk;

	// Compare a seen value with the expected one
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Print counts and verdict, then end the run
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Present one instruction, optionally follow it with another, sample the answer
	task automatic exec(input sis_pkg::sis_op_e o, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d, input sis_pkg::sis_op_e nxt);
		@(posedge clk);
		op_valid  <= 1'b1;
		op        <= o;
		op_addr   <= a;
		op_bit    <= b;
		mem_rdata <= d;
		@(posedge clk);
		op_valid <= (nxt != sis_pkg::SIS_OP_NONE);
		op       <= nxt;
		#1;
		chk("op_done", op_done, 8'h01);
		chk("flags_we", flags_we, 8'h00);
	endtask

	// Decrement into the accumulator, with and without a skip
	task automatic t_dec_acc();
		exec(sis_pkg::SIS_OP_DEC_ACC, 8'h10, 3'h0, 8'h05, sis_pkg::SIS_OP_NONE);
		chk("acc dec", accumulator, 8'h04);
		chk("we dec acc", mem_we, 8'h00);
		chk("squash nz", squash, 8'h00);
		exec(sis_pkg::SIS_OP_DEC_ACC, 8'h11, 3'h0, 8'h01, sis_pkg::SIS_OP_NONE);
		chk("acc dec zero", accumulator, 8'h00);
		chk("squash zero", squash, 8'h01);
		@(posedge clk);
		#1;
		chk("squash one cycle", squash, 8'h00);
		$display("test dec_acc done");
	endtask

	// Memory-writing instructions from a table
	task automatic t_mem();
		sis_pkg::sis_op_e ops[5];
		logic [7:0]       din[5];
		logic [7:0]       dout[5];
		logic [4:0]       skp;
		logic [7:0]       acc0;
		ops  = '{sis_pkg::SIS_OP_DEC_MEM, sis_pkg::SIS_OP_DEC_MEM, sis_pkg::SIS_OP_INC_MEM,
			sis_pkg::SIS_OP_INC_MEM, sis_pkg::SIS_OP_SET_ALL};
		din  = '{8'h01, 8'h00, 8'hff, 8'h7f, 8'h3c};
		dout = '{8'h00, 8'hff, 8'h00, 8'h80, 8'hff};
		skp  = 5'b00101;
		acc0 = 8'h00; // Left by the zero result at the end of t_dec_acc
		for (int i = 0; i < 5; i++) begin
			exec(ops[i], 8'h20 + 8'(i), 3'h0, din[i], sis_pkg::SIS_OP_NONE);
			chk("mem we", mem_we, 8'h01);
			chk("mem addr", mem_waddr, 8'h20 + 8'(i));
			chk("mem data", mem_wdata, dout[i]);
			chk("mem skip", squash, {7'h00, skp[i]});
			chk("acc kept", accumulator, acc0);
		end
		$display("test mem done");
	endtask

	// Increment into the accumulator
	task automatic t_inc_acc();
		exec(sis_pkg::SIS_OP_INC_ACC, 8'h30, 3'h0, 8'hff, sis_pkg::SIS_OP_NONE);
		chk("acc inc zero", accumulator, 8'h00);
		chk("squash inc", squash, 8'h01);
		chk("we inc acc", mem_we, 8'h00);
		exec(sis_pkg::SIS_OP_INC_ACC, 8'h31, 3'h0, 8'h41, sis_pkg::SIS_OP_NONE);
		chk("acc inc", accumulator, 8'h42);
		chk("squash inc nz", squash, 8'h00);
		$display("test inc_acc done");
	endtask

	// Set and test every bit position
	task automatic t_bits();
		for (int i = 0; i < 8; i++) begin
			exec(sis_pkg::SIS_OP_SET_BIT, 8'h40, 3'(i), 8'h5a, sis_pkg::SIS_OP_NONE);
			chk("set bit", mem_wdata, 8'h5a | (8'h01 << i));
			chk("set bit we", mem_we, 8'h01);
			exec(sis_pkg::SIS_OP_SKIP_BIT, 8'h41, 3'(i), 8'h5a, sis_pkg::SIS_OP_NONE);
			chk("bit skip", squash, 8'((8'h5a >> i) & 8'h01));
			chk("bit test we", mem_we, 8'h00);
		end
		$display("test bits done");
	endtask

	// Instruction offered in the dummy slot must have no effect
	task automatic t_squash();
		exec(sis_pkg::SIS_OP_INC_MEM, 8'h50, 3'h0, 8'hff, sis_pkg::SIS_OP_SET_ALL);
		chk("squash set", squash, 8'h01);
		@(posedge clk);
		op_valid <= 1'b0;
		op       <= sis_pkg::SIS_OP_NONE;
		#1;
		chk("dummy no write", mem_we, 8'h00);
		chk("dummy no done", op_done, 8'h00);
		chk("dummy data kept", mem_wdata, 8'h00);
		$display("test squash done");
	endtask

	// Reset in mid-run returns the outputs to their reset values, then runs again
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("mid rst acc", accumulator, 8'h00);
		chk("mid rst addr", mem_waddr, 8'h00);
		chk("mid rst data", mem_wdata, 8'h00);
		chk("mid rst squash", squash, 8'h00);
		exec(sis_pkg::SIS_OP_INC_ACC, 8'h60, 3'h0, 8'h10, sis_pkg::SIS_OP_NONE);
		chk("acc after rst", accumulator, 8'h11);
		$display("test reset done");
	endtask

	// Watchdog cuts a hang short
	initial begin
		#(3000 * 100);
		failures++;
		stop_test();
	end

	// Main sequence
	initial begin
		clk       = 1'b0;
		rst       = 1'b1;
		op_valid  = 1'b0;
		op        = sis_pkg::SIS_OP_NONE;
		op_addr   = 8'h00;
		op_bit    = 3'h0;
		mem_rdata = 8'h00;
		failures  = 0;
		n_checks  = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("rst acc", accumulator, 8'h00);
		chk("rst we", mem_we, 8'h00);
		chk("rst squash", squash, 8'h00);
		t_dec_acc();
		t_mem();
		t_inc_acc();
		t_bits();
		t_squash();
		t_reset();
		stop_test();
	end

endmodule
